// file: hdl/spi_frame_crc_status.v
`timescale 1ns/100ps
`include "spi_frame_defines.vh"

module spi_frame_crc_status #(
  parameter CTRL_WORDS = 64
) (
  input  wire          clk_i,
  input  wire          rst_b_i,
  input  wire          ce_i,
  input  wire          sclk_i,
  input  wire          csn_b_i,
  input  wire          sdi_i,
  input  wire [2:0]    mode_i,
  input  wire          crc_active_i,
  input  wire [111:0]  status_set_i,
  output reg           sdo_o,
  output reg           sdo_oe_b_o,
  output reg           wr_stb_o,
  output reg  [6:0]    wr_addr_o,
  output reg  [15:0]   wr_data_o,
  output reg           frame_err_o,
  output wire [111:0]  status_o
);

  function [7:0] crc8;
    input [23:0] d;
    integer      b;
    integer      i;
    reg     [7:0] c;
    begin
      c = `CRC_INIT;
      for (b = 0; b < 3; b = b + 1) begin
        for (i = 7; i >= 0; i = i - 1) begin
          if (c[7] ^ d[b*8+i]) begin
            c = {c[6:0], 1'b0} ^ `CRC_POLY;
          end else begin
            c = {c[6:0], 1'b0};
          end
        end
      end
      crc8 = c ^ `CRC_XOROUT;
    end
  endfunction

  // Pin synchronisers
  reg  [1:0]  sclk_s_q;
  reg  [1:0]  csn_s_q;
  reg  [1:0]  sdi_s_q;
  reg         sclk_p_q;
  reg         csn_p_q;
  reg  [31:0] rx_q;
  reg  [31:0] tx_q;
  reg  [5:0]  fall_cnt_q;
  reg  [5:0]  rise_cnt_q;
  reg         active_q;
  reg         err_q;
  reg  [15:0] ctrl_q [0:CTRL_WORDS-1];
  reg         cmd_rej_set;
  reg         crc_fail_set;
  reg  [15:0] rd_data;
  reg  [6:0]  clr_vec;
  integer     k;
  integer     j;
  integer     r;

  wire        spi_on     = (mode_i == `MODE_INIT) || (mode_i == `MODE_NORMAL) ||
                           (mode_i == `MODE_STOP);
  wire        sclk_fall  = sclk_p_q & ~sclk_s_q[1];
  wire        sclk_rise  = ~sclk_p_q & sclk_s_q[1];
  wire        csn_fall   = csn_p_q & ~csn_s_q[1];
  wire        csn_rise   = ~csn_p_q & csn_s_q[1];
  wire [31:0] rx_next    = {sdi_s_q[1], rx_q[31:1]};
  wire [6:0]  hdr_addr   = rx_next[31:25];
  wire [6:0]  addr       = rx_q[`ADDR_MSB:`ADDR_LSB];
  wire        dir        = rx_q[`DIR_BIT];
  wire [15:0] cmd_data   = rx_q[`DATA_MSB:`DATA_LSB];
  wire [7:0]  cmd_crc    = rx_q[`CRC_MSB:`CRC_LSB];
  wire [111:0] stat_w;
  wire [7:0]  summary;

  // Status registers, one per group
  genvar g;
  generate
    for (g = 0; g < `STAT_GROUPS; g = g + 1) begin : g_stat
      reg  [15:0] q;
      wire [15:0] set_w;
      if (g == `DEV_GROUP) begin : g_dev
        assign set_w = status_set_i[g*16+:16] |
                       ({15'h0000, cmd_rej_set} << `CMD_REJ_BIT) |
                       ({15'h0000, crc_fail_set} << `CRC_FAIL_BIT);
      end else begin : g_plain
        assign set_w = status_set_i[g*16+:16];
      end
      always @(posedge clk_i) begin
        if (!rst_b_i) begin
          q <= `STAT_RST;
        end else if (ce_i) begin
          // Set wins over a clear in the same cycle; no self-clearing
          q <= (clr_vec[g] ? 16'h0000 : q) | set_w;
        end
      end
      if (g == `DEV_GROUP) begin : g_crcstat
        assign stat_w[g*16+:16] = (q & ~(16'h0001 << `CRC_STAT_BIT)) |
                                  ({15'h0000, crc_active_i} << `CRC_STAT_BIT);
      end else begin : g_out
        assign stat_w[g*16+:16] = q;
      end
      if (g == `DEV_GROUP) begin : g_sum_dev
        assign summary[g] = |(stat_w[g*16+:16] & ~(16'h0001 << `CRC_STAT_BIT) &
                              ~(16'h0001 << `SRST_IND_BIT));
      end else begin : g_sum
        assign summary[g] = |stat_w[g*16+:16];
      end
    end
  endgenerate

  assign summary[7] = stat_w[`DEV_GROUP*16+`CMD_REJ_BIT] |
                      stat_w[`DEV_GROUP*16+`CRC_FAIL_BIT];
  assign status_o   = stat_w;

  function [6:0] grp_addr;
    input integer n;
    begin
      case (n)
        0:       grp_addr = `SUP_STAT_ADDR;
        1:       grp_addr = `THERMAL_STATUS_REG_ADDR;
        2:       grp_addr = `BUS_STAT_ADDR;
        3:       grp_addr = `WAKE_STAT_ADDR;
        4:       grp_addr = `SUM_HIGHSIDE_BIT_ADDR;
        5:       grp_addr = `DEV_STAT_ADDR;
        default: grp_addr = `DSF_STAT_ADDR;
      endcase
    end
  endfunction

  // Read data for the address seen after the seventh falling edge
  always @* begin
    rd_data = 16'h0000;
    if (hdr_addr < `STAT_BASE) begin
      if (hdr_addr < CTRL_WORDS) begin
        rd_data = ctrl_q[hdr_addr[5:0]];
      end
    end else begin
      for (k = 0; k < `STAT_GROUPS; k = k + 1) begin
        if (hdr_addr == grp_addr(k)) begin
          rd_data = stat_w[k*16+:16];
        end
      end
    end
  end

  // End of frame decode
  wire frame_done = csn_rise & active_q;
  wire len_ok     = (fall_cnt_q == 6'd32);
  wire len_bad    = (fall_cnt_q != 6'd0) && !len_ok;
  wire rd_dev     = (addr == `DEV_STAT_ADDR) && !dir;
  wire crc_ok     = crc_active_i ? (cmd_crc == crc8(rx_q[23:0]))
                                 : (cmd_crc == `CRC_FILL_IN);
  wire accept     = frame_done && len_ok && (crc_ok || rd_dev);
  wire wr_allowed = (mode_i == `MODE_INIT) || (mode_i == `MODE_NORMAL) ||
                    ((mode_i == `MODE_STOP) &&
                     ((addr == `MODE_CTRL_ADDR) || (addr == `WDOG_CTRL_ADDR)));
  wire is_ctrl    = (addr < `STAT_BASE);
  wire do_write   = accept && dir && is_ctrl && wr_allowed && (addr < CTRL_WORDS);

  always @* begin
    crc_fail_set = frame_done && len_ok && !crc_ok && !rd_dev;
    cmd_rej_set  = accept && dir && is_ctrl && !wr_allowed;
    // Own loop index: a shared one would be driven from several processes
    for (j = 0; j < `STAT_GROUPS; j = j + 1) begin
      clr_vec[j] = accept && dir && (addr == grp_addr(j));
    end
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      sclk_s_q    <= 2'b00;
      csn_s_q     <= 2'b11;
      sdi_s_q     <= 2'b00;
      sclk_p_q    <= 1'b0;
      csn_p_q     <= 1'b1;
    end else if (ce_i) begin
      sclk_s_q    <= {sclk_s_q[0], sclk_i};
      csn_s_q     <= {csn_s_q[0], csn_b_i};
      sdi_s_q     <= {sdi_s_q[0], sdi_i};
      sclk_p_q    <= sclk_s_q[1];
      csn_p_q     <= csn_s_q[1];
    end
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      rx_q        <= 32'h0000_0000;
      tx_q        <= 32'h0000_0000;
      fall_cnt_q  <= 6'd0;
      rise_cnt_q  <= 6'd0;
      active_q    <= 1'b0;
      err_q       <= 1'b0;
      sdo_o       <= 1'b0;
      sdo_oe_b_o  <= 1'b1;
      wr_stb_o    <= 1'b0;
      wr_addr_o   <= 7'h00;
      wr_data_o   <= 16'h0000;
      frame_err_o <= 1'b0;
      for (r = 0; r < CTRL_WORDS; r = r + 1) begin
        ctrl_q[r] <= `CTRL_RST;
      end
    end else if (ce_i) begin
      wr_stb_o    <= 1'b0;
      frame_err_o <= err_q;
      if (csn_fall && spi_on) begin
        active_q   <= 1'b1;
        fall_cnt_q <= 6'd0;
        rise_cnt_q <= 6'd0;
        // Summary frozen here: later events show up next frame
        tx_q       <= {24'h00_0000, summary};
        sdo_o      <= err_q;
        sdo_oe_b_o <= 1'b0;
        err_q      <= 1'b0;
      end else if (active_q && !csn_s_q[1]) begin
        if (sclk_fall) begin
          rx_q <= rx_next;
          if (fall_cnt_q != 6'd63) begin
            fall_cnt_q <= fall_cnt_q + 6'd1;
          end
          if (fall_cnt_q == 6'd6) begin
            tx_q[31:8] <= {(crc_active_i ? crc8({rd_data, tx_q[7:0]}) : `CRC_FILL_OUT),
                           rd_data};
          end
        end
        if (sclk_rise) begin
          sdo_o <= (rise_cnt_q < 6'd32) ? tx_q[rise_cnt_q[4:0]] : 1'b0;
          if (rise_cnt_q != 6'd63) begin
            rise_cnt_q <= rise_cnt_q + 6'd1;
          end
        end
      end
      if (csn_rise) begin
        active_q   <= 1'b0;
        sdo_oe_b_o <= 1'b1;
        sdo_o      <= 1'b0;
      end
      if (!spi_on) begin
        active_q   <= 1'b0;
        sdo_oe_b_o <= 1'b1;
      end
      if (frame_done && len_bad) begin
        err_q <= 1'b1;
      end
      if (do_write) begin
        ctrl_q[addr[5:0]] <= cmd_data;
        wr_stb_o          <= 1'b1;
        wr_addr_o         <= addr;
        wr_data_o         <= cmd_data;
      end
    end
  end

endmodule

// file: common/spi_frame_defines.vh
`ifndef SPI_FRAME_DEFINES_VH
`define SPI_FRAME_DEFINES_VH

// Frame layout, bit 0 travels first
`define FRAME_BITS       32
`define ADDR_LSB         0
`define ADDR_MSB         6
`define DIR_BIT          7
`define DATA_LSB         8
`define DATA_MSB         23
`define CRC_LSB          24
`define CRC_MSB          31

// CRC8, polynomial 0x2F
`define CRC_POLY         8'h2F
`define CRC_INIT         8'hFF
`define CRC_XOROUT       8'hFF
`define CRC_FILL_IN      8'hA5
`define CRC_FILL_OUT     8'h5A

// Device modes
`define MODE_INIT        3'h0
`define MODE_NORMAL      3'h1
`define MODE_STOP        3'h2
`define MODE_SLEEP       3'h3
`define MODE_RESTART     3'h4
`define MODE_FAILSAFE    3'h5

// Control registers below this address, status at and above
`define STAT_BASE        7'h40
`define MODE_CTRL_ADDR   7'h01
`define WDOG_CTRL_ADDR   7'h03

// Status register addresses, group order equals summary bit order
`define SUP_STAT_ADDR    7'h40
`define THERMAL_STATUS_REG_ADDR  7'h41
`define BUS_STAT_ADDR    7'h42
`define WAKE_STAT_ADDR   7'h43
`define SUM_HIGHSIDE_BIT_ADDR     7'h44
`define DEV_STAT_ADDR    7'h45
`define DSF_STAT_ADDR    7'h50
`define STAT_GROUPS      7
`define DEV_GROUP        5

// Device status bit positions
`define CMD_REJ_BIT      0
`define CRC_FAIL_BIT     1
`define SRST_IND_BIT     14
`define CRC_STAT_BIT     15

// Reset values
`define CTRL_RST         16'h0000
`define STAT_RST         16'h0000

`endif

// file: tb/spi_frame_crc_status_assertions.sv
`timescale 1ns/100ps
module spi_frame_crc_status_assertions (
  input logic         clk_i,
  input logic         rst_b_i,
  input logic         sclk_i,
  input logic         csn_b_i,
  input logic [2:0]   mode_i,
  input logic         crc_active_i,
  input logic [111:0] status_set_i,
  input logic         sdo_o,
  input logic         sdo_oe_b_o,
  input logic         wr_stb_o,
  input logic [6:0]   wr_addr_o,
  input logic [111:0] status_o
);
  // Bit 95 mirrors the CRC setting, so sticky checks skip it
  localparam logic [111:0] M = ~(112'h1 << 95);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence open_s;
    $fell(csn_b_i) && mode_i <= 3'h2;
  endsequence
  sequence held_s;
    (!csn_b_i)[*6];
  endsequence
  a_set_sticks: assert property (
    |(status_set_i & M) |=> (status_o & $past(status_set_i) & M) == ($past(status_set_i) & M))
    else $error("status flag not set");
  a_no_drop: assert property (
    !csn_b_i && !$past(csn_b_i) |-> (M & $past(status_o) & ~status_o) == 112'h0)
    else $error("status flag dropped mid frame");
  a_crc_mirror: assert property (status_o[95] == crc_active_i)
    else $error("crc active bit wrong");
  a_off_quiet: assert property (mode_i >= 3'h3 && $past(mode_i) >= 3'h3 |-> sdo_oe_b_o)
    else $error("sdo driven while off");
  a_restart_mute: assert property ((mode_i == 3'h4)[*8] |-> !wr_stb_o)
    else $error("write in restart");
  a_stop_limit: assert property (
    (mode_i == 3'h2)[*8] ##0 wr_stb_o |-> wr_addr_o == 7'h01 || wr_addr_o == 7'h03)
    else $error("illegal write in stop");
  a_stb_single: assert property (wr_stb_o |=> !wr_stb_o)
    else $error("write strobe too long");
  a_write_late: assert property (wr_stb_o |-> csn_b_i && $past(csn_b_i, 3))
    else $error("write before frame end");
  a_float_end: assert property (csn_b_i[*6] |-> sdo_oe_b_o)
    else $error("sdo not released");
  a_drive_open: assert property (open_s ##1 held_s |-> !sdo_oe_b_o)
    else $error("sdo not driven");
  a_sdo_quiet: assert property ((!sclk_i && !csn_b_i)[*8] |-> $stable(sdo_o))
    else $error("sdo moved without clock rise");
endmodule

bind spi_frame_crc_status spi_frame_crc_status_assertions chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .sclk_i(sclk_i), .csn_b_i(csn_b_i), .mode_i(mode_i), .crc_active_i(crc_active_i),
  .status_set_i(status_set_i), .sdo_o(sdo_o), .sdo_oe_b_o(sdo_oe_b_o), .wr_stb_o(wr_stb_o),
  .wr_addr_o(wr_addr_o), .status_o(status_o));

// file: tb/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
  input  logic        clk_i,
  input  logic        sdo_i,
  output logic        sclk_o,
  output logic        csn_b_o,
  output logic        sdi_o,
  output logic        done_o,
  output logic [32:0] rsp_o
);
  initial begin
    sclk_o = 0;
    csn_b_o = 1;
    sdi_o = 0;
    done_o = 0;
    rsp_o = '0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Clock idles low at both select edges; data changes well after the falling edge
  task automatic xfer(input logic [31:0] c, input int n);
    rsp_o = 'x;
    csn_b_o = 0;
    sdi_o = c[0];
    w(10);
    rsp_o[32] = sdo_i;
    for (int i = 0; i < n; i++) begin
      sclk_o = 1;
      w(4);
      sclk_o = 0;
      w(2);
      sdi_o = c[(i + 1) % 32];
      w(6);
      rsp_o[i] = sdo_i;
    end
    csn_b_o = 1;
    // Released data line flips rather than holding its last value
    sdi_o = ~sdi_o;
    done_o = 1;
    w(1);
    done_o = 0;
    w(8);
  endtask
endmodule

// file: tb/spi_frame_crc_status_test.sv
`timescale 1ns/100ps
`include "spi_frame_defines.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module spi_frame_crc_status_test;
  logic         clk_i = 0;
  logic         rst_b_i = 0;
  logic         crc_active_i = 0;
  logic [2:0]   mode_i = `MODE_INIT;
  logic [111:0] status_set_i = '0;
  wire          sclk, csn_b, sdi, done, sdo_o, sdo_oe_b_o;
  wire  [32:0]  rsp;
  wire  [6:0]   wra;
  wire  [15:0]  wrd;
  wire          ferr;
  wire          sdo_w = sdo_oe_b_o ? 1'bz : sdo_o;
  int           n_mismatch = 0, tests_run = 0, nclk = 32, b;
  logic         bad = 0, ee = 0;
  logic [65:0]  q[$];
  logic [15:0]  v, v2;
  logic [6:0]   a;
  logic [6:0]   sa[7] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h50};
  spi_frame_crc_status dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .sclk_i(sclk), .csn_b_i(csn_b),
    .sdi_i(sdi), .mode_i(mode_i), .crc_active_i(crc_active_i), .status_set_i(status_set_i), .sdo_o(sdo_o),
    .sdo_oe_b_o(sdo_oe_b_o), .wr_stb_o(), .wr_addr_o(wra), .wr_data_o(wrd), .frame_err_o(ferr), .status_o());
  spi_host_model host (.clk_i(clk_i), .sdo_i(sdo_w), .sclk_o(sclk), .csn_b_o(csn_b), .sdi_o(sdi),
    .done_o(done), .rsp_o(rsp));
  initial forever #25 clk_i = ~clk_i;
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c = 8'hff;
    for (int i = 0; i < 24; i++) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[(i / 8) * 8 + 7 - i % 8]) ? 8'h2f : 8'h00);
    return c ^ 8'hff;
  endfunction
  // Frames cut short or sent while off are not checked by the monitor
  task automatic tx(input logic [6:0] ad, input logic dr, input logic [15:0] dv,
                    input logic [15:0] pm, pe, input logic [7:0] sm, se);
    logic [23:0] f = {dv, dr, ad};
    q.push_back(nclk == 32 && mode_i <= 3'h2 ? {1'b1, 8'hff, pm, sm, ee, 8'h00, pe, se} : 66'h0);
    host.xfer({(crc_active_i ? crc8(f) : 8'ha5) ^ {8{bad}}, f}, nclk);
  endtask
  always @(posedge done) begin
    logic [32:0] m, e;
    {m, e} = q.pop_front();
    if (m[31]) e[31:24] = crc_active_i ? crc8(rsp[23:0]) : 8'h5a;
    `CHK(rsp & m, e & m)
  end
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #2_000_000;
    n_mismatch++;
    conclude();
  end
  initial begin
    v = 16'($urandom(32'h0000_94e3));
    v2 = ~v;
    a = 7'h04 + 7'($urandom % 60);
    repeat (20) @(negedge clk_i);
    rst_b_i = 1;
    @(negedge clk_i);
    `CHK(crc8(24'h83_01f2), 8'hc2)
    tx(a, 1, v, 16'hffff, 16'h0, 8'hff, 8'h0);
    `CHK({wra, wrd}, {a, v})
    mode_i = `MODE_NORMAL;
    tx(a, 0, v2, 16'hffff, v, 8'h0, 8'h0);
    tx(a, 1, v2, 16'hffff, v, 8'h0, 8'h0);
    for (int g = 0; g < 7; g++) begin
      // Bits 0 and 1 of the device group also raise summary bit 7, 14 and 15 are excluded
      b = 2 + $urandom % 12;
      status_set_i[g * 16 + b] = 1;
      @(negedge clk_i);
      status_set_i = '0;
      tx(sa[g], 1, 16'($urandom), 16'hffff, 16'h1 << b, 8'hff, 8'h1 << g);
      tx(sa[g], 0, 16'h0, 16'hffff, 16'h0, 8'hff, 8'h0);
    end
    fork
      tx(7'h45, 0, 16'h0, 16'h0, 16'h0, 8'hff, 8'h0);
      begin
        repeat (150) @(negedge clk_i);
        status_set_i[94] = 1;
        status_set_i[16] = 1;
        @(negedge clk_i);
        status_set_i = '0;
      end
    join
    tx(7'h41, 1, 16'h0, 16'hffff, 16'h1, 8'hff, 8'h02);
    tx(7'h45, 1, 16'h0, 16'hffff, 16'h4000, 8'hff, 8'h0);
    bad = 1;
    tx(a, 1, v, 16'h0, 16'h0, 8'h0, 8'h0);
    bad = 0;
    tx(7'h45, 1, 16'h0, 16'h0002, 16'h0002, 8'h80, 8'h80);
    tx(a, 0, 16'h0, 16'hffff, v2, 8'h80, 8'h0);
    crc_active_i = 1;
    tx(7'h45, 0, 16'h0, 16'h8000, 16'h8000, 8'hff, 8'h0);
    bad = 1;
    repeat (2) tx(7'h45, 0, 16'h0, 16'h0002, 16'h0, 8'h80, 8'h0);
    tx(a, 1, v, 16'h0, 16'h0, 8'h0, 8'h0);
    bad = 0;
    tx(7'h45, 1, 16'h0, 16'h8002, 16'h8002, 8'h80, 8'h80);
    tx(7'h45, 0, 16'h0, 16'h8002, 16'h8000, 8'h80, 8'h0);
    tx(a, 1, v, 16'hffff, v2, 8'h0, 8'h0);
    mode_i = `MODE_STOP;
    tx(a, 1, v2, 16'hffff, v, 8'h0, 8'h0);
    `CHK({wra, wrd}, {a, v})
    tx(7'h03, 1, v2, 16'h0, 16'h0, 8'h0, 8'h0);
    `CHK({wra, wrd}, {7'h03, v2})
    tx(7'h45, 1, 16'h0, 16'h0001, 16'h0001, 8'h80, 8'h80);
    tx(7'h03, 0, 16'h0, 16'hffff, v2, 8'h80, 8'h0);
    mode_i = `MODE_RESTART;
    tx(a, 1, v2, 16'h0, 16'h0, 8'h0, 8'h0);
    `CHK({wra, wrd}, {7'h03, v2})
    mode_i = `MODE_NORMAL;
    tx(a, 0, 16'h0, 16'hffff, v, 8'h0, 8'h0);
    nclk = 31;
    tx(a, 1, v2, 16'h0, 16'h0, 8'h0, 8'h0);
    `CHK(ferr, 1'b1)
    `CHK({wra, wrd}, {7'h03, v2})
    nclk = 32;
    ee = 1;
    tx(a, 0, 16'h0, 16'hffff, v, 8'h0, 8'h0);
    ee = 0;
    `CHK(ferr, 1'b0)
    tx(a, 0, 16'h0, 16'hffff, v, 8'h0, 8'h0);
    conclude();
  end
endmodule
